// >>> hw/fam_mapper.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RQ1] Both low kernel regions map to lowest 512MB by dropping upper bits.
// [RQ2] Error-level clear: low user region gets one gigabyte added.
// [RQ3] Error-level set: low user region passes through unchanged.
// [RQ4] Regions from 0xC000_0000 upward map by identity.
// [RQ5] No supervisor mode exists; only user and kernel privilege.
// [RQ6] User access to kernel regions raises address error before translation.
// [RQ7] Upper kernel regions take cacheability from setup bits 30:28.
// [RQ8] Error-level clear: user region cacheability from setup bits 27:25.
// [RQ9] New fields share the cached kernel field coding; kernel field still used.
// [RQ10] Error-level set: user region data references are uncached.
// [RQ11] Uncached unmapped kernel region is always uncached.
// [RQ12] Software must not set error level while fetching from user region.
// [RQ13] Page-table interface registers are absent; their accesses are undefined.
// [RQ14] The four translation-table instructions raise reserved instruction exception.
// [RQ15] Segment chosen from bits 31:29; result ready in one access cycle.
module fam_mapper (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Translation port
  input wire fam_pkg::fam_req_t req,
  output fam_pkg::fam_rsp_t rsp,
  // Instruction decode port
  input wire logic op_valid,
  input wire fam_pkg::fam_op_t op,
  output logic rsvd_insn_exc,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt
  output logic irq
);
  import fam_pkg::*;

  // Address regions picked by the top three address bits
  typedef enum {
    FAM_REG_USER,
    FAM_REG_CACHED_LOW,
    FAM_REG_UNCACHED_LOW,
    FAM_REG_UPPER
  } fam_region_t;

  // Software-visible registers
  logic [31:0] setup_r;
  logic [31:0] ctrl_r;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] irq_en_r;

  // Attribute fields of the setup word
  logic [2:0] upper_attr;
  logic [2:0] user_attr;
  logic [2:0] kern_attr;

  // Error level flag from the control word
  logic error_level_flag;

  // Request decode
  fam_region_t req_region;
  logic req_upper_half;
  logic req_low_user;

  // Result and exception before their output registers
  fam_rsp_t rsp_nxt;
  logic rsvd_nxt;

  // Register port decode
  logic wr_setup;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  logic [31:0] rdata_nxt;

  // Events, clear mask and sticky status
  logic [EV_W-1:0] ev_now;
  logic [EV_W-1:0] clr_mask;
  logic [EV_W-1:0] status_nxt;
  logic irq_nxt;

  // Region of a virtual address from bits 31:29
  function automatic fam_region_t region_of(input logic [31:0] va);
    logic [2:0] seg;

    seg = va[SEG_HI:SEG_LO];
    if (!seg[2]) begin
      region_of = FAM_REG_USER;
    end else if (seg == SEG_CACHED_UNMAPPED) begin
      region_of = FAM_REG_CACHED_LOW;
    end else if (seg == SEG_UNCACHED_UNMAPPED) begin
      region_of = FAM_REG_UNCACHED_LOW;
    end else begin
      region_of = FAM_REG_UPPER;
    end
  endfunction

  // Physical address of a virtual address
  // User relocation never carries out: bit 31 is clear in that region
  function automatic logic [31:0] xlate(input fam_region_t rg, input logic [31:0] va, input logic erl_f);
    logic [31:0] pa;

    pa = va;
    case (rg)
      FAM_REG_USER: begin
        if (erl_f) begin
          pa = va; // RQ3
        end else begin
          pa = va + USER_RELOC_ADD; // RQ2
        end
      end
      FAM_REG_CACHED_LOW: pa = va & LOW_512M_MASK; // RQ1
      FAM_REG_UNCACHED_LOW: pa = va & LOW_512M_MASK; // RQ1
      FAM_REG_UPPER: pa = va; // RQ4
      default: pa = va;
    endcase
    xlate = pa;
  endfunction

  // Cache attribute; the new fields share the cached kernel field coding
  function automatic logic [2:0] attr_of(input fam_region_t rg, input logic erl_f, input logic [2:0] upper_f,
                                         input logic [2:0] user_f, input logic [2:0] kern_f);
    logic [2:0] at;

    at = ATTR_UNCACHED;
    case (rg)
      FAM_REG_USER: begin
        // Fetch under error level is undefined; treated like data
        if (erl_f) begin
          at = ATTR_UNCACHED; // RQ10
        end else begin
          at = user_f; // RQ8
        end
      end
      FAM_REG_CACHED_LOW: at = kern_f; // RQ9
      FAM_REG_UNCACHED_LOW: at = ATTR_UNCACHED; // RQ11
      FAM_REG_UPPER: at = upper_f; // RQ7
      default: at = ATTR_UNCACHED;
    endcase
    attr_of = at;
  endfunction

  // The four translation-table instructions
  function automatic logic is_table_op(input fam_op_t o);
    logic hit;

    hit = 1'b0;
    case (o)
      FAM_OP_WRITE_RANDOM: hit = 1'b1; // RQ14
      FAM_OP_WRITE_INDEXED: hit = 1'b1; // RQ14
      FAM_OP_PROBE: hit = 1'b1; // RQ14
      FAM_OP_READ: hit = 1'b1; // RQ14
      default: hit = 1'b0;
    endcase
    is_table_op = hit;
  endfunction

  // Read mux; unmapped offsets, page-table ones included, read zero
  function automatic logic [31:0] reg_read(input logic [3:0] a, input logic [31:0] setup_f,
                                           input logic [31:0] ctrl_f, input logic [EV_W-1:0] st_f,
                                           input logic [EV_W-1:0] en_f);
    logic [31:0] d;

    case (a)
      OFS_SETUP: d = setup_f;
      OFS_CTRL: d = ctrl_f;
      OFS_STATUS: d = {{(32 - EV_W){1'b0}}, st_f};
      OFS_IRQ_EN: d = {{(32 - EV_W){1'b0}}, en_f};
      default: d = 32'h0000_0000; // RQ13
    endcase
    reg_read = d;
  endfunction

  // Setup word fields and error level
  assign upper_attr = setup_r[UPPER_ATTR_HI:UPPER_ATTR_LO]; // RQ7
  assign user_attr = setup_r[USER_ATTR_HI:USER_ATTR_LO]; // RQ8
  assign kern_attr = setup_r[KERN_ATTR_HI:KERN_ATTR_LO]; // RQ9
  assign error_level_flag = ctrl_r[CTRL_ERL_BIT];

  // Request decode
  assign req_region = region_of(req.vaddr); // RQ15
  assign req_upper_half = req.vaddr[SEG_HI];
  assign req_low_user = (req_region == FAM_REG_USER);

  // Translation result, combinational part
  // The attribute is still computed for a faulting access
  always_comb begin
    rsp_nxt.valid = req.valid;
    // Only user and kernel modes; any upper half address faults in user mode
    rsp_nxt.addr_err = req.valid && req.user_mode && req_upper_half; // RQ5 RQ6
    if (rsp_nxt.addr_err) begin
      rsp_nxt.paddr = 32'h0000_0000; // RQ6
    end else begin
      rsp_nxt.paddr = xlate(req_region, req.vaddr, error_level_flag); // RQ15
    end
    rsp_nxt.attr = attr_of(req_region, error_level_flag, upper_attr, user_attr, kern_attr); // RQ15
  end

  // Translation result register, one cycle
  // A new request may be taken every cycle; no state is kept between them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp <= '0;
    end else begin
      rsp <= rsp_nxt;
    end
  end

  // Reserved instruction detection
  assign rsvd_nxt = op_valid && is_table_op(op); // RQ14

  // Reserved instruction exception register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsvd_insn_exc <= 1'b0;
    end else begin
      rsvd_insn_exc <= rsvd_nxt;
    end
  end

  // Register port write decode; other offsets are ignored
  assign wr_setup = reg_wr && (reg_addr == OFS_SETUP);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_clr = reg_wr && (reg_addr == OFS_IRQ_CLR);
  assign wr_en = reg_wr && (reg_addr == OFS_IRQ_EN);

  // Setup register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setup_r <= SETUP_RST;
    end else if (wr_setup) begin
      setup_r <= reg_wdata;
    end
  end

  // Control register, error level only
  // A change reaches translation from the next request on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= {31'h0000_0000, reg_wdata[CTRL_ERL_BIT]};
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_en_r <= '0;
    end else if (wr_en) begin
      irq_en_r <= reg_wdata[EV_W-1:0];
    end
  end

  // Event sources: address error, reserved insn, user fetch under error level
  assign ev_now[EV_ADDR_ERR] = rsp_nxt.addr_err; // RQ6
  assign ev_now[EV_RSVD_INSN] = rsvd_nxt; // RQ14
  assign ev_now[EV_ERL_FETCH] = req.valid && req.fetch && error_level_flag && req_low_user; // RQ12

  // Status next value, set wins over clear
  assign clr_mask = wr_clr ? reg_wdata[EV_W-1:0] : '0;
  assign status_nxt = (status_r & ~clr_mask) | ev_now;

  // Sticky status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Interrupt output, one cycle behind the status
  assign irq_nxt = |(status_r & irq_en_r);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // Read data, only in the cycle after the strobe
  assign rdata_nxt = reg_rd ? reg_read(reg_addr, setup_r, ctrl_r, status_r, irq_en_r) : 32'h0000_0000;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> hw/fam_pkg.sv
package fam_pkg;

  // Address and attribute widths
  localparam int ADDR_W = 32;
  localparam int ATTR_W = 3;
  localparam int REG_AW = 4;

  // Segment select field position
  localparam int SEG_HI = 31;
  localparam int SEG_LO = 29;

  // Segment codes from address bits 31:29
  localparam logic [2:0] SEG_CACHED_UNMAPPED = 3'h4;
  localparam logic [2:0] SEG_UNCACHED_UNMAPPED = 3'h5;

  // Relocation constants
  localparam logic [31:0] USER_RELOC_ADD = 32'h4000_0000;
  localparam logic [31:0] LOW_512M_MASK = 32'h1fff_ffff;

  // Setup register field positions
  localparam int UPPER_ATTR_HI = 30;
  localparam int UPPER_ATTR_LO = 28;
  localparam int USER_ATTR_HI = 27;
  localparam int USER_ATTR_LO = 25;
  localparam int KERN_ATTR_HI = 2;
  localparam int KERN_ATTR_LO = 0;

  // Coherency encoding for uncached references
  localparam logic [2:0] ATTR_UNCACHED = 3'h2;

  // Register offsets
  localparam logic [3:0] OFS_SETUP = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h3;
  localparam logic [3:0] OFS_IRQ_EN = 4'h4;

  // Control bit positions
  localparam int CTRL_ERL_BIT = 0;

  // Reset values (setup field has none documented; chosen here)
  localparam logic [31:0] SETUP_RST = 32'h2400_0002;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // Event bit positions in the status register
  localparam int EV_ADDR_ERR = 0;
  localparam int EV_RSVD_INSN = 1;
  localparam int EV_ERL_FETCH = 2;
  localparam int EV_W = 3;

  // Translation-table instruction kinds
  typedef enum logic [2:0] {
    FAM_OP_NONE,
    FAM_OP_WRITE_RANDOM,
    FAM_OP_WRITE_INDEXED,
    FAM_OP_PROBE,
    FAM_OP_READ,
    FAM_OP_OTHER
  } fam_op_t;

  // Translation request from the pipeline
  typedef struct packed {
    logic valid;
    logic fetch;
    logic user_mode;
    logic [31:0] vaddr;
  } fam_req_t;

  // Translation result to the pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] paddr;
    logic [2:0] attr;
    logic addr_err;
  } fam_rsp_t;

endpackage

// >>> verif/fam_mapper_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fam_mapper_checker (
  // Watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire fam_pkg::fam_req_t req,
  input wire fam_pkg::fam_rsp_t rsp,
  input wire logic op_valid,
  input wire fam_pkg::fam_op_t op,
  input wire logic rsvd_insn_exc
);
  import fam_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Kernel request and table op decode
  logic kr, tab_op;
  assign kr = req.valid && !req.user_mode;
  assign tab_op = op_valid && op inside {[FAM_OP_WRITE_RANDOM:FAM_OP_READ]};
  chk_low_kern: assert property (
    kr && req.vaddr[31:30] == 2'h2 |=> rsp.paddr == ($past(req.vaddr) & LOW_512M_MASK)) else $error("bad low map");
  chk_upper_ident: assert property (
    kr && req.vaddr[31:30] == 2'h3 |=> rsp.paddr == $past(req.vaddr)) else $error("bad upper map");
  chk_unc_attr: assert property (
    req.valid && req.vaddr[31:29] == SEG_UNCACHED_UNMAPPED |=> rsp.attr == ATTR_UNCACHED) else $error("bad attr");
  chk_user_err: assert property (
    req.valid && req.user_mode && req.vaddr[31] |=> rsp.addr_err && rsp.paddr == 32'h0) else $error("no addr err");
  chk_low_ok: assert property (
    req.valid && !req.vaddr[31] |=> !rsp.addr_err) else $error("false addr err");
  chk_rsvd_fire: assert property (
    tab_op |=> rsvd_insn_exc) else $error("no rsvd exc");
  chk_rsvd_quiet: assert property (
    !tab_op |=> !rsvd_insn_exc) else $error("false rsvd exc");
  chk_rsp_valid: assert property (
    1'b1 |=> rsp.valid == $past(req.valid)) else $error("bad rsp valid");
  // Main scenarios
  cover property (tab_op);
  cover property (req.valid && req.user_mode && req.vaddr[31]);
  cover property (kr && req.vaddr[31:29] == SEG_CACHED_UNMAPPED);
endmodule
bind fam_mapper fam_mapper_checker u_chk (.clk, .rstn, .req, .rsp, .op_valid, .op, .rsvd_insn_exc);
`default_nettype wire

// >>> verif/fam_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fam_mapper_tb;
  import fam_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rsvd_insn_exc, irq;
  fam_req_t req;
  fam_rsp_t rsp;
  fam_op_t op = FAM_OP_NONE;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int bad_count = 0, checked = 0;
  fam_pipe_model u_pipe (.clk, .req);
  fam_mapper DUT (.clk, .rstn, .req, .rsp, .op_valid, .op, .rsvd_insn_exc, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq);
  // Clock and watchdog
  initial forever #2 clk = ~clk;
  initial begin
    #20000;
    bad_count++;
    summarize();
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask
  task automatic xl(input logic u, input logic [31:0] va, pa, input logic [2:0] at, input logic er);
    u_pipe.issue(u, va);
    #1 cmp(rsp.paddr, pa);
    cmp({31'h0, rsp.valid}, 32'h1);
    cmp({29'h0, rsp.attr}, {29'h0, at});
    cmp({31'h0, rsp.addr_err}, {31'h0, er});
  endtask
  // Reset values, unmapped place, then translation table
  task automatic t_map();
    rd(OFS_SETUP, SETUP_RST);
    rd(OFS_CTRL, CTRL_RST);
    rd(4'hf, 32'h0);
    xl(1'b0, 32'h7fff_ffff, 32'h7fff_ffff, ATTR_UNCACHED, 1'b0);
    wr(OFS_CTRL, 32'h0);
    xl(1'b0, 32'h0, USER_RELOC_ADD, SETUP_RST[27:25], 1'b0);
    xl(1'b0, 32'h9fff_ffff, 32'h1fff_ffff, SETUP_RST[2:0], 1'b0);
    xl(1'b0, 32'ha000_0000, 32'h0, ATTR_UNCACHED, 1'b0);
    xl(1'b0, 32'hc000_0000, 32'hc000_0000, SETUP_RST[30:28], 1'b0);
    wr(OFS_SETUP, 32'h1a00_0003);
    xl(1'b0, 32'hffff_ffff, 32'hffff_ffff, 3'h1, 1'b0);
    xl(1'b0, 32'h7fff_fff0, 32'hbfff_fff0, 3'h5, 1'b0);
    xl(1'b0, 32'h8000_0040, 32'h0000_0040, 3'h3, 1'b0);
  endtask
  // User access to kernel space, then interrupt enable and clear
  task automatic t_err();
    xl(1'b1, 32'hb000_0000, 32'h0, ATTR_UNCACHED, 1'b1);
    xl(1'b1, 32'h0000_0010, 32'h4000_0010, 3'h5, 1'b0);
    cmp({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h1);
    rd(OFS_STATUS, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    rd(OFS_STATUS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
  endtask
  // Every op kind; only the four table ops trap
  task automatic t_ops();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      op_valid <= 1'b1;
      op <= fam_op_t'(i);
      @(posedge clk);
      op_valid <= 1'b0;
      #1 cmp({31'h0, rsvd_insn_exc}, (i >= 1 && i <= 4) ? 32'h1 : 32'h0);
    end
    rd(OFS_STATUS, 32'h2);
    cmp({31'h0, irq}, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_map();
    t_err();
    t_ops();
    summarize();
  end
endmodule
`default_nettype wire

// >>> verif/fam_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module fam_pipe_model (
  // Clock and request
  input wire logic clk,
  output fam_pkg::fam_req_t req
);
  import fam_pkg::*;
  initial req = '0;
  // One access, then scramble the dropped address
  task automatic issue(input logic usr, input logic [31:0] va);
    @(posedge clk);
    req <= '{1'b1, 1'b0, usr, va};
    @(posedge clk);
    req <= '{1'b0, 1'b0, usr, ~va};
  endtask
endmodule
`default_nettype wire
